/* tb.sv */
// self-checking bench for the frame event monitor with the line model
// assumes a shortened excessive-crc window of 3000 cycles, so 8-cycle multiframes can exceed it
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata;
	logic o_irq_n;
	tfe_pkg::tfe_line_t line;
	tfe_pkg::tfe_overhead_t oh = '0;
	logic [6:0] frames = 7'h0C;
	logic slc = 1'b0;
	logic oof = 1'b1;
	logic err = 1'b0;
	logic mimic = 1'b0;
	logic moved = 1'b0;
	logic crc_bad = 1'b0;
	int n_fail = 0;
	int n_compared = 0;
	always #25 i_clock = ~i_clock;
	tfe_line_model u_tfe_line_model (.i_clock(i_clock), .i_rst(i_rst), .i_frames(frames), .i_slc(slc),
		.i_oof(oof), .i_err(err), .i_mimic(mimic), .i_moved(moved), .i_crc_bad(crc_bad), .i_oh(oh),
		.o_line(line));
	tfe_monitor #(.EXCESS_CYCLES(3000)) u_tfe_monitor (.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_line(line), .o_irq_n(o_irq_n));
	task results;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			n_fail++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
		@(posedge i_clock);
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		@(negedge i_clock);
		chk(o_rdata & m, e);
		@(posedge i_clock);
	endtask
	task irq(input logic e);
		@(negedge i_clock);
		chk({7'h00, o_irq_n}, {7'h00, e});
		@(posedge i_clock);
	endtask
	task t_regs;
		logic [7:0] addrs [9] = '{8'h50, 8'h51, 8'h52, 8'h53, 8'h56, 8'h57, 8'h58, 8'h5C, 8'h5D};
		foreach (addrs[k])
			rdc(addrs[k], 8'hFF, 8'h00);
		wr(8'h56, 8'hFF);
		wr(8'h60, 8'hFF);
		rdc(8'h56, 8'hFF, 8'h00);
		rdc(8'h60, 8'hFF, 8'h00);
		wr(8'h50, 8'hFF);
		wr(8'h51, 8'hFF);
		wr(8'h5C, 8'hFF);
		rdc(8'h50, 8'hFF, 8'h19);
		rdc(8'h51, 8'hFF, 8'h1F);
		rdc(8'h5C, 8'hFF, 8'h1F);
		wr(8'h50, 8'h00);
		wr(8'h51, 8'h00);
		wr(8'h5C, 8'h00);
	endtask
	task t_oof_and_start;
		wr(8'h53, 8'hFF);
		repeat (60) @(posedge i_clock);
		rdc(8'h53, 8'h10, 8'h00);
		wr(8'h50, 8'h01);
		oof <= 1'b0;
		repeat (3) @(posedge i_clock);
		irq(1'b0);
		rdc(8'h52, 8'h01, 8'h01);
		rdc(8'h4F, 8'hFF, 8'h00);
		wr(8'h52, 8'h01);
		irq(1'b1);
		wr(8'h51, 8'h10);
		repeat (60) @(posedge i_clock);
		irq(1'b0);
		rdc(8'h53, 8'h10, 8'h10);
		wr(8'h51, 8'h00);
		wr(8'h50, 8'h00);
		oof <= 1'b1;
		repeat (3) @(posedge i_clock);
		irq(1'b1);
		rdc(8'h52, 8'h01, 8'h01);
		oof <= 1'b0;
		repeat (3) @(posedge i_clock);
		wr(8'h52, 8'hFF);
		wr(8'h53, 8'hFF);
	endtask
	task t_fbit;
		err <= 1'b1;
		@(posedge i_clock iff line.fbit_stb);
		err <= 1'b0;
		repeat (2) @(posedge i_clock);
		rdc(8'h53, 8'h0A, 8'h02);
		wr(8'h53, 8'hFF);
		wr(8'h51, 8'h08);
		// three in a row so two share any fixed window
		err <= 1'b1;
		repeat (3) @(posedge i_clock iff line.fbit_stb);
		err <= 1'b0;
		repeat (3) @(posedge i_clock);
		irq(1'b0);
		rdc(8'h53, 8'h08, 8'h08);
		wr(8'h51, 8'h00);
		wr(8'h53, 8'hFF);
		irq(1'b1);
	endtask
	task t_pulses;
		for (int k = 0; k < 2; k++)
		begin
			wr(8'h40, k == 0 ? 8'h02 : 8'h01);
			frames <= (k == 0) ? 7'h0C : 7'h18;
			wr(8'h52, 8'hFF);
			mimic <= 1'b1;
			@(posedge i_clock);
			mimic <= 1'b0;
			repeat (2) @(posedge i_clock);
			rdc(8'h52, 8'h08, k == 0 ? 8'h00 : 8'h08);
		end
		wr(8'h53, 8'hFF);
		moved <= 1'b1;
		@(posedge i_clock);
		moved <= 1'b0;
		repeat (2) @(posedge i_clock);
		rdc(8'h53, 8'h01, 8'h01);
	endtask
	task t_crc;
		repeat (300) @(posedge i_clock);
		wr(8'h53, 8'hFF);
		wr(8'h52, 8'hFF);
		repeat (300) @(posedge i_clock);
		rdc(8'h53, 8'h04, 8'h00);
		crc_bad <= 1'b1;
		repeat (300) @(posedge i_clock);
		rdc(8'h53, 8'h04, 8'h04);
		rdc(8'h52, 8'h10, 8'h00);
		// one error per 8-cycle multiframe: 375 in a full window
		frames <= 7'h02;
		repeat (7000) @(posedge i_clock);
		rdc(8'h52, 8'h10, 8'h10);
		crc_bad <= 1'b0;
	endtask
	task t_slc;
		wr(8'h40, 8'h03);
		frames <= 7'h48;
		slc <= 1'b1;
		oh <= '{conc: 11'h5A3, maint: 3'h5, sw: 4'hA, alarm: 2'h2};
		repeat (880) @(posedge i_clock);
		rdc(8'h56, 8'hFF, 8'hA3);
		rdc(8'h57, 8'hFF, 8'h2D);
		rdc(8'h58, 8'hFF, 8'h2A);
		rdc(8'h5D, 8'h0F, 8'h0F);
		oof <= 1'b1;
		oh <= '1;
		repeat (300) @(posedge i_clock);
		rdc(8'h56, 8'hFF, 8'hA3);
		wr(8'h5C, 8'h10);
		oof <= 1'b0;
		// the second frame in sync only primes the debounce, the third commits
		repeat (2) @(posedge i_clock iff line.mf_start);
		rdc(8'h56, 8'hFF, 8'hA3);
		@(posedge i_clock iff line.mf_start);
		rdc(8'h56, 8'hFF, 8'hFF);
	endtask
	initial
	begin
		repeat (16) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		t_regs;
		t_oof_and_start;
		t_fbit;
		t_pulses;
		t_crc;
		t_slc;
		results;
	end
	initial
	begin
		repeat (20000) @(posedge i_clock);
		n_fail++;
		results;
	end
endmodule
`default_nettype wire

/* tfe_line_model.sv */
// far-side model: a framed bit stream in 4-bit frames, F bit first, crc-6 in frames 2,6..22
// assumes the bench steers sync, F-bit errors, pulses and overhead values
`timescale 1ns/10ps
`default_nettype none
module tfe_line_model (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// controls
	input wire logic [6:0] i_frames,
	input wire logic i_slc,
	input wire logic i_oof,
	input wire logic i_err,
	input wire logic i_mimic,
	input wire logic i_moved,
	input wire logic i_crc_bad,
	input wire tfe_pkg::tfe_overhead_t i_oh,
	// line
	output tfe_pkg::tfe_line_t o_line
);
	logic [1:0] pos_ff;
	logic [6:0] frm_ff;
	logic fs;
	logic fbit;
	int n;
	logic [5:0] run_ff;
	logic [5:0] tx_ff;
	function automatic logic [5:0] crc_next(input logic [5:0] c, input logic d);
		crc_next = {c[4:0], 1'b0} ^ ((c[5] ^ d) ? tfe_pkg::CRC6_POLY : 6'h00);
	endfunction
	// crc of each multiframe with F bits taken as one, sent in the next multiframe
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			run_ff <= 6'h00;
			tx_ff <= 6'h00;
		end
		else if (o_line.mf_start)
		begin
			tx_ff <= run_ff;
			run_ff <= crc_next(6'h00, 1'b1);
		end
		else
			run_ff <= crc_next(run_ff, o_line.data_bit | o_line.fbit_stb);
	end
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			pos_ff <= 2'h0;
			frm_ff <= 7'h01;
		end
		else
		begin
			pos_ff <= pos_ff + 2'h1;
			if (pos_ff == 2'h3)
				frm_ff <= (frm_ff >= i_frames) ? 7'h01 : frm_ff + 7'h01;
		end
	end
	// overhead rides on the Fs bits of even frames
	always_comb
	begin
		n = int'(frm_ff) / 2;
		fs = 1'b0;
		if (n >= 12 && n <= 22)
			fs = i_oh.conc[n - 12];
		else if (n >= 24 && n <= 26)
			fs = i_oh.maint[n - 24];
		else if (n >= 27 && n <= 28)
			fs = i_oh.alarm[n - 27];
		else if (n >= 29 && n <= 32)
			fs = i_oh.sw[n - 29];
		fbit = (frm_ff[0] || !i_slc) ? frm_ff[1] : fs;
		if (!i_slc && frm_ff[1:0] == 2'h2)
			fbit = tx_ff[3'h5 - frm_ff[4:2]] ^ i_crc_bad;
		o_line.bit_stb = 1'b1;
		o_line.fbit_stb = (pos_ff == 2'h0);
		// payload toggles so a stale value never looks like a framing bit
		o_line.data_bit = (pos_ff == 2'h0) ? fbit : pos_ff[0];
		o_line.fbit_check = (pos_ff == 2'h0) && !i_slc;
		o_line.fbit_expect = fbit ^ i_err;
		o_line.frame_num = frm_ff;
		o_line.mf_start = (pos_ff == 2'h0) && (frm_ff == 7'h01);
		o_line.oof = i_oof;
		o_line.mimic_det = i_mimic;
		o_line.align_moved = i_moved;
	end
endmodule
`default_nettype wire

/* tfe_monitor.sv */
// receive frame event flags, crc-6 check and slc-96 overhead extraction
// assumes the aligner strobes are synchronous to i_clock; frame_num counts 1..N in the multiframe
//
// What this block does
// - loss-change enable gates loss-change flag to interrupt
// - second enable register masks five framing flags
// - flags sticky until software writes one
// - esf: over 319 crc errors per second
// - sf/esf: mimic pattern sets false-pattern flag
// - loss-change flag on every frame-loss edge
// - frame start flag per multiframe, frozen out-of-sync
// - sf/dm: two Ft errors in six frames
// - esf: two alignment errors in one multiframe
// - esf crc-6 checked against next multiframe
// - sf/esf/dm: framing bit mismatch flagged where the aligner marks it checked, in sync
// - slc: odd Ft and Fs 2n checked
// - alignment move flag on new F position
// - concentrator field split low eight, high three
// - maintenance, switch, alarm fields readable, bit1 lsb
// - debounce needs two equal frames, else every frame
// - overhead fields held while out of sync
// - debounce control bit, resets to zero
// - frame loss status readable, one when unsynced
// - overhead field changes set change flags; the enables gate only the interrupt
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module tfe_monitor #(
	parameter int EXCESS_CYCLES = tfe_pkg::EXCESS_WINDOW_CYCLES
)(
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// aligner side
	input wire tfe_pkg::tfe_line_t i_line,
	// interrupt
	output logic o_irq_n
);

	localparam int WIN_W = $clog2(EXCESS_CYCLES + 1);

	logic [1:0] format_ff;
	logic [7:0] loss_en_ff;
	logic [7:0] err_en_ff;
	logic [7:0] oh_en_ff;
	logic [7:0] loss_flags_ff;
	logic [7:0] err_flags_ff;
	logic [7:0] oh_flags_ff;
	logic [7:0] rdata_ff;
	logic irq_n_ff;
	logic oof_d_ff;
	logic [4:0] sev_frames_ff;
	logic [1:0] sev_errs_ff;
	logic [5:0] crc_run_ff;
	logic [5:0] crc_prev_ff;
	logic [5:0] crc_rx_ff;
	logic crc_prev_ok_ff;
	logic crc_run_ok_ff;
	logic [WIN_W-1:0] sec_cnt_ff;
	logic [9:0] crc_errs_ff;
	tfe_pkg::tfe_overhead_t oh_rx_ff;
	tfe_pkg::tfe_overhead_t oh_last_ff;
	tfe_pkg::tfe_overhead_t oh_out_ff;
	logic oh_last_ok_ff;
	logic slc_ok_ff;

	tfe_pkg::tfe_format_t fmt;
	logic is_sf_dm;
	logic is_esf;
	logic is_slc;
	logic fbit_mis;
	logic slc_checked;
	logic fbit_err;
	logic ft_err;
	logic sev_win_end;
	logic sev_hit;
	logic crc_err;
	logic excess_hit;
	logic sec_end;
	logic [6:0] fs_idx;
	logic oh_commit;
	logic oh_take;
	tfe_pkg::tfe_overhead_t nxt_oh_out;
	logic [7:0] loss_set;
	logic [7:0] err_set;
	logic [7:0] oh_set;
	logic [7:0] wr_clr_loss;
	logic [7:0] wr_clr_err;
	logic [7:0] wr_clr_oh;

	function automatic logic [5:0] crc6_step(input logic [5:0] crc, input logic din);
		logic fb;
		fb = crc[5] ^ din;
		crc6_step = {crc[4:0], 1'b0} ^ (fb ? tfe_pkg::CRC6_POLY : tfe_pkg::CRC6_SEED);
	endfunction

	assign fmt = tfe_pkg::tfe_format_t'(format_ff);
	assign is_sf_dm = (fmt == tfe_pkg::FMT_SF) || (fmt == tfe_pkg::FMT_DM);
	assign is_esf = (fmt == tfe_pkg::FMT_ESF);
	assign is_slc = (fmt == tfe_pkg::FMT_SLC);
	assign fbit_mis = i_line.fbit_stb && (i_line.data_bit != i_line.fbit_expect) && !i_line.oof;
	assign fs_idx = {1'b0, i_line.frame_num[6:1]};

	// slc: Ft in odd frames, Fs in frame 2n for 0<n<12 and n=36
	assign slc_checked = i_line.frame_num[0] || ((fs_idx != 7'h00) && (fs_idx <= tfe_pkg::SLC_FS_LAST_SYNC))
		|| (fs_idx == tfe_pkg::SLC_FS_EXTRA_SYNC);
	assign fbit_err = fbit_mis && (is_slc ? slc_checked : i_line.fbit_check);
	// the aligner marks only Ft positions as checked in sf and dm
	assign ft_err = fbit_err && !is_slc;

	// register port
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			format_ff <= 2'h0;
			loss_en_ff <= tfe_pkg::RESET_BYTE;
			err_en_ff <= tfe_pkg::RESET_BYTE;
			oh_en_ff <= tfe_pkg::RESET_BYTE;
		end
		else if (i_wr)
		begin
			if (i_addr == tfe_pkg::ADDR_FORMAT)
				format_ff <= i_wdata[1:0];
			else if (i_addr == tfe_pkg::ADDR_LOSS_EN)
				loss_en_ff <= i_wdata & 8'h19;
			else if (i_addr == tfe_pkg::ADDR_ERR_EN)
				err_en_ff <= i_wdata & 8'h1F;
			else if (i_addr == tfe_pkg::ADDR_OH_EN)
				oh_en_ff <= i_wdata & 8'h1F;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			rdata_ff <= tfe_pkg::RESET_BYTE;
		else if (!i_rd)
			rdata_ff <= tfe_pkg::RESET_BYTE;
		else if (i_addr == tfe_pkg::ADDR_FORMAT)
			rdata_ff <= {6'h00, format_ff};
		else if (i_addr == tfe_pkg::ADDR_STATUS)
			rdata_ff <= {7'h00, oof_d_ff};
		else if (i_addr == tfe_pkg::ADDR_LOSS_EN)
			rdata_ff <= loss_en_ff;
		else if (i_addr == tfe_pkg::ADDR_ERR_EN)
			rdata_ff <= err_en_ff;
		else if (i_addr == tfe_pkg::ADDR_LOSS_FLAGS)
			rdata_ff <= loss_flags_ff;
		else if (i_addr == tfe_pkg::ADDR_ERR_FLAGS)
			rdata_ff <= err_flags_ff;
		else if (i_addr == tfe_pkg::ADDR_OH_CONC_LO)
			rdata_ff <= oh_out_ff.conc[7:0];
		else if (i_addr == tfe_pkg::ADDR_OH_MAINT_HI)
			rdata_ff <= {2'h0, oh_out_ff.maint, oh_out_ff.conc[10:8]};
		else if (i_addr == tfe_pkg::ADDR_OH_SW_ALARM)
			rdata_ff <= {2'h0, oh_out_ff.sw, oh_out_ff.alarm};
		else if (i_addr == tfe_pkg::ADDR_OH_EN)
			rdata_ff <= oh_en_ff;
		else if (i_addr == tfe_pkg::ADDR_OH_FLAGS)
			rdata_ff <= oh_flags_ff;
		else
			rdata_ff <= tfe_pkg::RESET_BYTE;
	end

	// frame loss status and its edge
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			oof_d_ff <= 1'b1;
		else
			oof_d_ff <= i_line.oof;
	end

	localparam logic [1:0] SEVERE_ERR_COUNT_M1 = tfe_pkg::SEVERE_ERR_COUNT - 2'h1;

	// severe window: six basic frames in sf/dm, one multiframe in esf
	assign sev_win_end = is_esf ? i_line.mf_start : (i_line.fbit_stb && (sev_frames_ff == tfe_pkg::SF_WINDOW_FRAMES - 5'h01));
	// the sixth F bit still belongs to its sf/dm window; in esf mf_start opens the next one
	assign sev_hit = (is_sf_dm || is_esf) && ft_err && (sev_errs_ff == SEVERE_ERR_COUNT_M1)
		&& !(is_esf && sev_win_end);

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			sev_frames_ff <= 5'h00;
			sev_errs_ff <= 2'h0;
		end
		else if (i_line.oof || sev_win_end)
		begin
			// in sf/dm an error on the closing bit of a window still counts in that window
			sev_frames_ff <= 5'h00;
			sev_errs_ff <= 2'h0;
		end
		else
		begin
			if (i_line.fbit_stb)
				sev_frames_ff <= sev_frames_ff + 5'h01;
			if (ft_err && sev_errs_ff != tfe_pkg::SEVERE_ERR_COUNT)
				sev_errs_ff <= sev_errs_ff + 2'h1;
		end
	end

	// crc-6 over each esf multiframe with F positions forced to one
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			crc_run_ff <= tfe_pkg::CRC6_SEED;
			crc_prev_ff <= tfe_pkg::CRC6_SEED;
			crc_rx_ff <= tfe_pkg::CRC6_SEED;
			crc_prev_ok_ff <= 1'b0;
			crc_run_ok_ff <= 1'b0;
		end
		else if (!is_esf || i_line.oof)
		begin
			// a crc started mid-multiframe is never compared
			crc_prev_ok_ff <= 1'b0;
			crc_run_ok_ff <= 1'b0;
		end
		else if (i_line.bit_stb)
		begin
			if (i_line.mf_start)
			begin
				crc_prev_ff <= crc_run_ff;
				crc_prev_ok_ff <= crc_run_ok_ff;
				crc_run_ok_ff <= 1'b1;
				crc_run_ff <= crc6_step(tfe_pkg::CRC6_SEED, i_line.data_bit | i_line.fbit_stb);
			end
			else
				crc_run_ff <= crc6_step(crc_run_ff, i_line.data_bit | i_line.fbit_stb);
			if (i_line.fbit_stb && i_line.frame_num[1:0] == tfe_pkg::CRC_FRAME_PHASE)
				crc_rx_ff[3'h5 - 3'(i_line.frame_num[4:2])] <= i_line.data_bit;
		end
	end

	// received bits in multiframe k carry the crc of multiframe k-1
	assign crc_err = is_esf && !i_line.oof && i_line.bit_stb && i_line.mf_start && crc_prev_ok_ff
		&& (crc_rx_ff != crc_prev_ff);

	// fixed one-second window of crc errors
	assign sec_end = (sec_cnt_ff == WIN_W'(EXCESS_CYCLES - 1));
	assign excess_hit = is_esf && crc_err && (crc_errs_ff == tfe_pkg::EXCESS_CRC_LIMIT);

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			sec_cnt_ff <= '0;
			crc_errs_ff <= 10'h000;
		end
		else if (sec_end)
		begin
			sec_cnt_ff <= '0;
			crc_errs_ff <= 10'h000;
		end
		else
		begin
			sec_cnt_ff <= sec_cnt_ff + WIN_W'(1);
			// saturate one above the limit so the event fires once per window
			if (crc_err && crc_errs_ff <= tfe_pkg::EXCESS_CRC_LIMIT)
				crc_errs_ff <= crc_errs_ff + 10'h001;
		end
	end

	// slc-96 overhead collection from Fs bits of even frames
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			oh_rx_ff <= '0;
		else if (is_slc && i_line.fbit_stb && !i_line.frame_num[0])
		begin
			if (fs_idx >= tfe_pkg::SLC_CONC_FIRST && fs_idx < tfe_pkg::SLC_CONC_FIRST + 7'h0B)
				oh_rx_ff.conc[4'(fs_idx - tfe_pkg::SLC_CONC_FIRST)] <= i_line.data_bit;
			else if (fs_idx >= tfe_pkg::SLC_MAINT_FIRST && fs_idx < tfe_pkg::SLC_ALARM_FIRST)
				oh_rx_ff.maint[2'(fs_idx - tfe_pkg::SLC_MAINT_FIRST)] <= i_line.data_bit;
			else if (fs_idx >= tfe_pkg::SLC_ALARM_FIRST && fs_idx < tfe_pkg::SLC_SWITCH_FIRST)
				oh_rx_ff.alarm[1'(fs_idx - tfe_pkg::SLC_ALARM_FIRST)] <= i_line.data_bit;
			else if (fs_idx >= tfe_pkg::SLC_SWITCH_FIRST && fs_idx <= tfe_pkg::SLC_SWITCH_LAST)
				oh_rx_ff.sw[2'(fs_idx - tfe_pkg::SLC_SWITCH_FIRST)] <= i_line.data_bit;
		end
	end

	// a full slc frame was seen in sync when the next one starts
	assign oh_commit = is_slc && i_line.mf_start && !i_line.oof && slc_ok_ff;
	assign oh_take = oh_commit;

	always_comb
	begin
		nxt_oh_out = oh_out_ff;
		if (oh_take)
		begin
			// each field debounces on its own
			if (!oh_en_ff[tfe_pkg::DEBOUNCE_BIT] || (oh_last_ok_ff && oh_last_ff.conc == oh_rx_ff.conc))
				nxt_oh_out.conc = oh_rx_ff.conc;
			if (!oh_en_ff[tfe_pkg::DEBOUNCE_BIT] || (oh_last_ok_ff && oh_last_ff.maint == oh_rx_ff.maint))
				nxt_oh_out.maint = oh_rx_ff.maint;
			if (!oh_en_ff[tfe_pkg::DEBOUNCE_BIT] || (oh_last_ok_ff && oh_last_ff.sw == oh_rx_ff.sw))
				nxt_oh_out.sw = oh_rx_ff.sw;
			if (!oh_en_ff[tfe_pkg::DEBOUNCE_BIT] || (oh_last_ok_ff && oh_last_ff.alarm == oh_rx_ff.alarm))
				nxt_oh_out.alarm = oh_rx_ff.alarm;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			oh_out_ff <= '0;
			oh_last_ff <= '0;
			oh_last_ok_ff <= 1'b0;
			slc_ok_ff <= 1'b0;
		end
		else
		begin
			oh_out_ff <= nxt_oh_out;
			if (!is_slc || i_line.oof)
			begin
				slc_ok_ff <= 1'b0;
				oh_last_ok_ff <= 1'b0;
			end
			else if (i_line.mf_start)
				slc_ok_ff <= 1'b1;
			if (oh_take)
			begin
				oh_last_ff <= oh_rx_ff;
				oh_last_ok_ff <= 1'b1;
			end
		end
	end

	// event sources
	always_comb
	begin
		loss_set = 8'h00;
		loss_set[tfe_pkg::LOSS_CHANGE_BIT] = i_line.oof ^ oof_d_ff;
		loss_set[tfe_pkg::FALSE_PATTERN_BIT] = i_line.mimic_det && (fmt == tfe_pkg::FMT_SF || is_esf);
		loss_set[tfe_pkg::EXCESS_CRC_BIT] = excess_hit;
		err_set = 8'h00;
		err_set[tfe_pkg::ALIGN_MOVE_BIT] = i_line.align_moved;
		err_set[tfe_pkg::FBIT_ERR_BIT] = fbit_err;
		err_set[tfe_pkg::CRC_ERR_BIT] = crc_err;
		err_set[tfe_pkg::SEVERE_BIT] = sev_hit;
		err_set[tfe_pkg::FRAME_START_BIT] = i_line.mf_start && !i_line.oof;
		oh_set = 8'h00;
		oh_set[tfe_pkg::CONC_BIT] = nxt_oh_out.conc != oh_out_ff.conc;
		oh_set[tfe_pkg::MAINT_BIT] = nxt_oh_out.maint != oh_out_ff.maint;
		oh_set[tfe_pkg::SWITCH_BIT] = nxt_oh_out.sw != oh_out_ff.sw;
		oh_set[tfe_pkg::ALARM_BIT] = nxt_oh_out.alarm != oh_out_ff.alarm;
	end

	assign wr_clr_loss = (i_wr && i_addr == tfe_pkg::ADDR_LOSS_FLAGS) ? i_wdata : 8'h00;
	assign wr_clr_err = (i_wr && i_addr == tfe_pkg::ADDR_ERR_FLAGS) ? i_wdata : 8'h00;
	assign wr_clr_oh = (i_wr && i_addr == tfe_pkg::ADDR_OH_FLAGS) ? i_wdata : 8'h00;

	// sticky flags; an event in the clearing cycle wins
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			loss_flags_ff <= tfe_pkg::RESET_BYTE;
			err_flags_ff <= tfe_pkg::RESET_BYTE;
			oh_flags_ff <= tfe_pkg::RESET_BYTE;
		end
		else
		begin
			loss_flags_ff <= (loss_flags_ff & ~wr_clr_loss) | loss_set;
			err_flags_ff <= (err_flags_ff & ~wr_clr_err) | err_set;
			oh_flags_ff <= (oh_flags_ff & ~wr_clr_oh) | oh_set;
		end
	end

	// interrupt pin, one cycle behind the flags
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
			irq_n_ff <= 1'b1;
		else
			irq_n_ff <= !(|(loss_flags_ff & loss_en_ff)
				|| |(err_flags_ff & err_en_ff)
				|| |(oh_flags_ff[3:0] & oh_en_ff[3:0]));
	end

	assign o_rdata = rdata_ff;
	assign o_irq_n = irq_n_ff;

endmodule

`default_nettype wire

/* tfe_monitor_asserts.sv */
// port-level checker for the frame event monitor
// assumes enables change only through the register port, mirrored here
`timescale 1ns/10ps
`default_nettype none
module tfe_monitor_asserts #(
	parameter int EXCESS_CYCLES = 2000
)(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire tfe_pkg::tfe_line_t i_line,
	input wire logic o_irq_n
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);
	logic [7:0] loss_en_ff;
	logic [7:0] err_en_ff;
	logic [7:0] oh_en_ff;
	logic en_any;
	always_ff @(posedge i_clock or posedge i_rst)
	begin
		if (i_rst)
		begin
			loss_en_ff <= 8'h00;
			err_en_ff <= 8'h00;
			oh_en_ff <= 8'h00;
		end
		else if (i_wr)
		begin
			if (i_addr == tfe_pkg::ADDR_LOSS_EN)
				loss_en_ff <= i_wdata & 8'h19;
			if (i_addr == tfe_pkg::ADDR_ERR_EN)
				err_en_ff <= i_wdata & 8'h1F;
			if (i_addr == tfe_pkg::ADDR_OH_EN)
				oh_en_ff <= i_wdata & 8'h1F;
		end
	end
	// debounce bit is not an interrupt enable
	assign en_any = |{loss_en_ff, err_en_ff, oh_en_ff[3:0]};
	sequence irq_low_s;
		##2 !o_irq_n;
	endsequence
	sequence rd_of_s(logic [7:0] a);
		$past(i_rd) && $past(i_addr) == a;
	endsequence
	status_read_a: assert property (rd_of_s(tfe_pkg::ADDR_STATUS) |-> o_rdata == {7'h00, $past(i_line.oof, 2)})
		else $error("status read mismatch");
	loss_en_rb_a: assert property (rd_of_s(tfe_pkg::ADDR_LOSS_EN) |-> o_rdata == $past(loss_en_ff))
		else $error("loss enable readback mismatch");
	err_en_rb_a: assert property (rd_of_s(tfe_pkg::ADDR_ERR_EN) |-> o_rdata == $past(err_en_ff))
		else $error("error enable readback mismatch");
	oh_en_rb_a: assert property (rd_of_s(tfe_pkg::ADDR_OH_EN) |-> o_rdata == $past(oh_en_ff))
		else $error("overhead enable readback mismatch");
	irq_idle_a: assert property (!en_any && !$past(en_any) |-> o_irq_n)
		else $error("interrupt low with no enable");
	irq_cause_a: assert property ($fell(o_irq_n) |-> $past(en_any))
		else $error("interrupt fell without enable");
	flag_sticky_a: assert property ($rose(o_irq_n) |-> $past(i_wr, 2))
		else $error("interrupt released without a write");
	oof_irq_a: assert property ($changed(i_line.oof) && loss_en_ff[0] && !i_wr |-> irq_low_s)
		else $error("frame loss change missed");
	fstart_irq_a: assert property (i_line.bit_stb && i_line.mf_start && !i_line.oof && err_en_ff[4] && !i_wr
		|-> irq_low_s)
		else $error("frame start missed");
endmodule
bind tfe_monitor tfe_monitor_asserts #(.EXCESS_CYCLES(EXCESS_CYCLES)) u_tfe_monitor_asserts (.i_clock(i_clock),
	.i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_line(i_line), .o_irq_n(o_irq_n));
`default_nettype wire

/* tfe_pkg.sv */
// package for the receive frame event and slc-96 overhead monitor
// assumes one 20 MHz clock and a frame aligner that supplies bit and frame timing
package tfe_pkg;

	// register offsets on the byte-wide register port
	localparam logic [7:0] ADDR_FORMAT = 8'h40;
	localparam logic [7:0] ADDR_STATUS = 8'h4F;
	localparam logic [7:0] ADDR_LOSS_EN = 8'h50;
	localparam logic [7:0] ADDR_ERR_EN = 8'h51;
	localparam logic [7:0] ADDR_LOSS_FLAGS = 8'h52;
	localparam logic [7:0] ADDR_ERR_FLAGS = 8'h53;
	localparam logic [7:0] ADDR_OH_CONC_LO = 8'h56;
	localparam logic [7:0] ADDR_OH_MAINT_HI = 8'h57;
	localparam logic [7:0] ADDR_OH_SW_ALARM = 8'h58;
	localparam logic [7:0] ADDR_OH_EN = 8'h5C;
	localparam logic [7:0] ADDR_OH_FLAGS = 8'h5D;

	// bit positions in loss enable / loss flags
	localparam int LOSS_CHANGE_BIT = 0;
	localparam int FALSE_PATTERN_BIT = 3;
	localparam int EXCESS_CRC_BIT = 4;
	// bit positions in error enable / error flags
	localparam int ALIGN_MOVE_BIT = 0;
	localparam int FBIT_ERR_BIT = 1;
	localparam int CRC_ERR_BIT = 2;
	localparam int SEVERE_BIT = 3;
	localparam int FRAME_START_BIT = 4;
	// bit positions in overhead enable / overhead flags
	localparam int CONC_BIT = 0;
	localparam int MAINT_BIT = 1;
	localparam int SWITCH_BIT = 2;
	localparam int ALARM_BIT = 3;
	localparam int DEBOUNCE_BIT = 4;

	localparam logic [7:0] RESET_BYTE = 8'h00;

	// error thresholds and windows
	localparam logic [9:0] EXCESS_CRC_LIMIT = 10'h13F;
	localparam logic [1:0] SEVERE_ERR_COUNT = 2'h2;
	localparam logic [4:0] SF_WINDOW_FRAMES = 5'h06;
	localparam int CLOCK_HZ = 20000000;
	localparam int EXCESS_WINDOW_S = 1;
	localparam int EXCESS_WINDOW_CYCLES = EXCESS_WINDOW_S * CLOCK_HZ;

	// crc-6 polynomial x^6 + x + 1, and where its bits sit in an esf multiframe
	localparam logic [5:0] CRC6_POLY = 6'h03;
	localparam logic [5:0] CRC6_SEED = 6'h00;
	localparam logic [1:0] CRC_FRAME_PHASE = 2'h2;

	// slc-96 frame positions and Fs index layout of the overhead fields
	localparam logic [6:0] SLC_FS_LAST_SYNC = 7'h0B;
	localparam logic [6:0] SLC_FS_EXTRA_SYNC = 7'h24;
	localparam logic [6:0] SLC_CONC_FIRST = 7'h0C;
	localparam logic [6:0] SLC_MAINT_FIRST = 7'h18;
	localparam logic [6:0] SLC_ALARM_FIRST = 7'h1B;
	localparam logic [6:0] SLC_SWITCH_FIRST = 7'h1D;
	localparam logic [6:0] SLC_SWITCH_LAST = 7'h20;

	typedef enum logic [1:0] {
		FMT_SF,
		FMT_ESF,
		FMT_DM,
		FMT_SLC
	} tfe_format_t;

	// timing and status from the frame aligner, one bit period at a time
	typedef struct packed {
		logic bit_stb;
		logic data_bit;
		logic fbit_stb;
		logic fbit_check;
		logic fbit_expect;
		logic [6:0] frame_num;
		logic mf_start;
		logic oof;
		logic mimic_det;
		logic align_moved;
	} tfe_line_t;

	// the four received slc-96 overhead fields
	typedef struct packed {
		logic [10:0] conc;
		logic [2:0] maint;
		logic [3:0] sw;
		logic [1:0] alarm;
	} tfe_overhead_t;

endpackage
